//--- logic/ccrb_charger_config.sv
`timescale 1ns/1ns
`include "ccrb_params.svh"
module ccrb_charger_config (
  input wire logic sys_clk,
  input wire logic rst,
  input ccrb_pkg::ccrb_req_t req,
  input wire logic battery_cool_or_warm,
  input wire logic charger_input_present,
  output logic [7:0] rdata,
  output ccrb_pkg::ccrb_ctrl_t ctrl
);
  import ccrb_pkg::*;

  logic [7:0] pq_q, pq_d;
  logic [7:0] dv_q, dv_d;
  logic [7:0] fc_q, fc_d;
  logic [7:0] ta_q, ta_d;
  logic [7:0] rdata_q, rdata_d;
  ccrb_ctrl_t ctrl_q, ctrl_d;
  logic cw_s1_q, cw_s2_q, in_s1_q, in_s2_q;
  logic [18:0] fast_ua, adj_ua;
  ccrb_term_t term;
  ccrb_timer_t tmr;

  always_comb begin
    pq_d = pq_q;
    dv_d = dv_q;
    fc_d = fc_q;
    ta_d = ta_q;
    rdata_d = rdata_q;
    if (req.wr_en) begin
      unique case (req.addr)
        `CCRB_ADDR_PQ_TERM_TOPOFF: pq_d = req.wdata;
        `CCRB_ADDR_DIE_TEMP_VSYS: dv_d = req.wdata;
        `CCRB_ADDR_FAST_CURRENT_TIMER: fc_d = req.wdata;
        `CCRB_ADDR_TEMP_ADJ_CURRENT: ta_d = req.wdata & `CCRB_TEMP_ADJ_WMASK;
        default: ;
      endcase
    end
    if (req.rd_en) begin
      unique case (req.addr)
        `CCRB_ADDR_PQ_TERM_TOPOFF: rdata_d = pq_q;
        `CCRB_ADDR_DIE_TEMP_VSYS: rdata_d = dv_q;
        `CCRB_ADDR_FAST_CURRENT_TIMER: rdata_d = fc_q;
        `CCRB_ADDR_TEMP_ADJ_CURRENT: rdata_d = ta_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // status pins come from the analog side, so they are synchronised
  always_ff @(posedge sys_clk) begin
    cw_s1_q <= battery_cool_or_warm;
    cw_s2_q <= cw_s1_q;
    in_s1_q <= charger_input_present;
    in_s2_q <= in_s1_q;
  end

  ccrb_current_decode u_fast (
    .code(fc_q[7:2]),
    .current_ua(fast_ua)
  );
  ccrb_current_decode u_adj (
    .code(ta_q[7:2]),
    .current_ua(adj_ua)
  );

  always_comb begin
    term = ccrb_term_t'(pq_q[4:3]);
    tmr = ccrb_timer_t'(fc_q[1:0]);
    ctrl_d.precharge_mv = 12'(`CCRB_PQ_BASE_MV + pq_q[7:5] * `CCRB_PQ_STEP_MV);
    unique case (term)
      CCRB_TERM_5P0: ctrl_d.term_pct_x2 = 5'h0A;
      CCRB_TERM_7P5: ctrl_d.term_pct_x2 = 5'h0F;
      CCRB_TERM_10P0: ctrl_d.term_pct_x2 = 5'h14;
      CCRB_TERM_15P0: ctrl_d.term_pct_x2 = 5'h1E;
    endcase
    ctrl_d.topoff_min = 6'(pq_q[2:0] * `CCRB_TOPOFF_STEP_MIN);
    ctrl_d.die_temp_c = 7'(`CCRB_DIE_BASE_C + ((dv_q[7:5] >= `CCRB_DIE_TEMP_CODE_MAX) ?
      `CCRB_DIE_TEMP_CODE_MAX : dv_q[7:5]) * `CCRB_DIE_STEP_C);
    // the 200mV headroom over charge voltage is left to software
    ctrl_d.system_mv = 13'(`CCRB_VSYS_BASE_MV + ((dv_q[4:0] >= `CCRB_VSYS_CODE_MAX) ?
      `CCRB_VSYS_CODE_MAX : dv_q[4:0]) * `CCRB_VSYS_STEP_MV);
    ctrl_d.charge_ua = cw_s2_q ? adj_ua : fast_ua;
    unique case (tmr)
      CCRB_TMR_OFF: ctrl_d.safety_timer_h = 4'h0;
      CCRB_TMR_3H: ctrl_d.safety_timer_h = 4'h3;
      CCRB_TMR_5H: ctrl_d.safety_timer_h = 4'h5;
      CCRB_TMR_7H: ctrl_d.safety_timer_h = 4'h7;
    endcase
    // thermistor bias is fed from the charger input
    ctrl_d.thermistor_active = ta_q[1] & in_s2_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pq_q <= `CCRB_RST_PQ_TERM_TOPOFF;
      dv_q <= `CCRB_RST_DIE_TEMP_VSYS;
      fc_q <= `CCRB_RST_FAST_CURRENT_TIMER;
      ta_q <= `CCRB_RST_TEMP_ADJ_CURRENT;
      rdata_q <= 8'h00;
      ctrl_q <= '0;
    end else begin
      pq_q <= pq_d;
      dv_q <= dv_d;
      fc_q <= fc_d;
      ta_q <= ta_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign rdata = rdata_q;
  assign ctrl = ctrl_q;

  property p_pq_reset;
    @(posedge sys_clk) rst |=> pq_q[7:5] == 3'h7;
  endproperty
  a_pq_reset: assert property (p_pq_reset) else $error("precharge reset wrong");
  property p_pq_mv;
    @(posedge sys_clk) disable iff (rst) 1 |=> ctrl.precharge_mv == 12'(
      12'h8FC + $past(pq_q[7:5]) * 12'h064);
  endproperty
  a_pq_mv: assert property (p_pq_mv) else $error("precharge decode wrong");
  // no past value here, so a one-cycle reset cannot leave a stale antecedent
  property p_term;
    @(posedge sys_clk) disable iff (rst) pq_q[4:3] == 2'h1 |=> ctrl.term_pct_x2 == 5'h0F;
  endproperty
  a_term: assert property (p_term) else $error("termination decode wrong");
  property p_term15;
    @(posedge sys_clk) disable iff (rst) pq_q[4:3] == 2'h3 |=> ctrl.term_pct_x2 == 5'h1E;
  endproperty
  a_term15: assert property (p_term15) else $error("top termination decode wrong");
  property p_topoff;
    @(posedge sys_clk) disable iff (rst) 1 |=> ctrl.topoff_min == 6'($past(pq_q[2:0]) * 6'h05);
  endproperty
  a_topoff: assert property (p_topoff) else $error("top-off decode wrong");
  property p_die;
    @(posedge sys_clk) disable iff (rst) dv_q[7] |=> ctrl.die_temp_c == 7'h64;
  endproperty
  a_die: assert property (p_die) else $error("die temperature decode wrong");
  property p_die_low;
    @(posedge sys_clk) disable iff (rst) dv_q[7:5] == 3'h0 |=> ctrl.die_temp_c == 7'h3C;
  endproperty
  a_die_low: assert property (p_die_low) else $error("die temperature base wrong");
  property p_die_step;
    @(posedge sys_clk) disable iff (rst) dv_q[7:5] == 3'h3 |=> ctrl.die_temp_c == 7'h5A;
  endproperty
  a_die_step: assert property (p_die_step) else $error("die temperature step wrong");
  property p_vsys;
    @(posedge sys_clk) disable iff (rst) dv_q[4:2] == 3'h7 |=> ctrl.system_mv == 13'h12C0;
  endproperty
  a_vsys: assert property (p_vsys) else $error("system voltage saturation wrong");
  property p_vsys_top;
    @(posedge sys_clk) disable iff (rst) dv_q[4:0] == 5'h1B |=> ctrl.system_mv == 13'h12A7;
  endproperty
  a_vsys_top: assert property (p_vsys_top) else $error("system voltage linear end wrong");
  property p_cur;
    @(posedge sys_clk) disable iff (rst) !cw_s2_q && fc_q[7:2] == 6'h26
      |=> ctrl.charge_ua == 19'h4_7694;
  endproperty
  a_cur: assert property (p_cur) else $error("fast current decode wrong");
  property p_cur_sat;
    @(posedge sys_clk) disable iff (rst) !cw_s2_q && fc_q[7:2] >= 6'h27
      |=> ctrl.charge_ua == 19'h4_93E0;
  endproperty
  a_cur_sat: assert property (p_cur_sat) else $error("fast current saturation wrong");
  property p_timer;
    @(posedge sys_clk) disable iff (rst) fc_q[1:0] == 2'h0 |=> ctrl.safety_timer_h == 4'h0;
  endproperty
  a_timer: assert property (p_timer) else $error("safety timer not off");
  property p_timer3;
    @(posedge sys_clk) disable iff (rst) fc_q[1:0] == 2'h1 |=> ctrl.safety_timer_h == 4'h3;
  endproperty
  a_timer3: assert property (p_timer3) else $error("safety timer short wrong");
  // a write lands on the next edge and reaches ctrl one edge later
  sequence s_write_timer7;
    req.wr_en && req.addr == `CCRB_ADDR_FAST_CURRENT_TIMER && req.wdata[1:0] == 2'h3;
  endsequence
  property p_timer7;
    @(posedge sys_clk) disable iff (rst) s_write_timer7 |-> ##2 ctrl.safety_timer_h == 4'h7;
  endproperty
  a_timer7: assert property (p_timer7) else $error("safety timer long wrong");
  property p_adj;
    @(posedge sys_clk) disable iff (rst) cw_s2_q && ta_q[7:2] == 6'h00
      |=> ctrl.charge_ua == 19'h1D4C;
  endproperty
  a_adj: assert property (p_adj) else $error("adjusted current not used");
  property p_adj_sat;
    @(posedge sys_clk) disable iff (rst) cw_s2_q && ta_q[7:2] >= 6'h27
      |=> ctrl.charge_ua == 19'h4_93E0;
  endproperty
  a_adj_sat: assert property (p_adj_sat) else $error("adjusted current saturation wrong");
  property p_thm;
    @(posedge sys_clk) disable iff (rst) ta_q[1] && in_s2_q |=> ctrl.thermistor_active;
  endproperty
  a_thm: assert property (p_thm) else $error("thermistor not enabled");
  property p_thm_off;
    @(posedge sys_clk) disable iff (rst) !ta_q[1] |=> !ctrl.thermistor_active;
  endproperty
  a_thm_off: assert property (p_thm_off) else $error("thermistor on while disabled");
  property p_thm_in;
    @(posedge sys_clk) disable iff (rst) !in_s2_q |=> !ctrl.thermistor_active;
  endproperty
  a_thm_in: assert property (p_thm_in) else $error("thermistor on without input");
  sequence s_read_pq;
    req.rd_en && req.addr == `CCRB_ADDR_PQ_TERM_TOPOFF;
  endsequence
  property p_read_pq;
    @(posedge sys_clk) disable iff (rst) s_read_pq |=> rdata == $past(pq_q);
  endproperty
  a_read_pq: assert property (p_read_pq) else $error("precharge register read wrong");
  sequence s_read_ta;
    req.rd_en && req.addr == `CCRB_ADDR_TEMP_ADJ_CURRENT;
  endsequence
  property p_bit0;
    @(posedge sys_clk) disable iff (rst) s_read_ta |=> !rdata[0];
  endproperty
  a_bit0: assert property (p_bit0) else $error("reserved bit reads one");
  sequence s_write_ta_bit0;
    req.wr_en && req.addr == `CCRB_ADDR_TEMP_ADJ_CURRENT && req.wdata[0];
  endsequence
  property p_ta_wmask;
    @(posedge sys_clk) disable iff (rst) s_write_ta_bit0 |=> !ta_q[0];
  endproperty
  a_ta_wmask: assert property (p_ta_wmask) else $error("reserved bit took a write");
endmodule : ccrb_charger_config

//--- logic/ccrb_params.svh
`ifndef CCRB_PARAMS_SVH
`define CCRB_PARAMS_SVH
`define CCRB_ADDR_PQ_TERM_TOPOFF 8'h22
`define CCRB_ADDR_DIE_TEMP_VSYS 8'h23
`define CCRB_ADDR_FAST_CURRENT_TIMER 8'h24
`define CCRB_ADDR_TEMP_ADJ_CURRENT 8'h25
`define CCRB_RST_PQ_TERM_TOPOFF 8'hF8
`define CCRB_RST_DIE_TEMP_VSYS 8'h10
`define CCRB_RST_FAST_CURRENT_TIMER 8'h05
`define CCRB_RST_TEMP_ADJ_CURRENT 8'h04
`define CCRB_TEMP_ADJ_WMASK 8'hFE
`define CCRB_CURRENT_CODE_MAX 6'h27
`define CCRB_VSYS_CODE_MAX 5'h1C
`define CCRB_DIE_TEMP_CODE_MAX 3'h4
`define CCRB_PQ_BASE_MV 12'h8FC
`define CCRB_PQ_STEP_MV 12'h064
`define CCRB_VSYS_BASE_MV 13'h1004
`define CCRB_VSYS_STEP_MV 13'h0019
`define CCRB_CUR_STEP_UA 19'h01D4C
`define CCRB_TOPOFF_STEP_MIN 6'h05
`define CCRB_DIE_BASE_C 7'h3C
`define CCRB_DIE_STEP_C 7'h0A
`endif

//--- logic/ccrb_pkg.sv
package ccrb_pkg;
  typedef enum logic [1:0] {
    CCRB_TERM_5P0 = 2'h0,
    CCRB_TERM_7P5 = 2'h1,
    CCRB_TERM_10P0 = 2'h2,
    CCRB_TERM_15P0 = 2'h3
  } ccrb_term_t;
  typedef enum logic [1:0] {
    CCRB_TMR_OFF = 2'h0,
    CCRB_TMR_3H = 2'h1,
    CCRB_TMR_5H = 2'h2,
    CCRB_TMR_7H = 2'h3
  } ccrb_timer_t;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ccrb_req_t;
  typedef struct packed {
    logic [11:0] precharge_mv;
    logic [4:0] term_pct_x2;
    logic [5:0] topoff_min;
    logic [6:0] die_temp_c;
    logic [12:0] system_mv;
    logic [18:0] charge_ua;
    logic [3:0] safety_timer_h;
    logic thermistor_active;
  } ccrb_ctrl_t;
endpackage : ccrb_pkg

//--- logic/ccrb_current_decode.sv
`timescale 1ns/1ns
`include "ccrb_params.svh"
// one linear current decoder, used for normal and cool/warm current
module ccrb_current_decode (
  input wire logic [5:0] code,
  output logic [18:0] current_ua
);
  logic [5:0] sat;
  always_comb begin
    sat = (code >= `CCRB_CURRENT_CODE_MAX) ? `CCRB_CURRENT_CODE_MAX : code;
    current_ua = 19'((sat + 6'h01) * `CCRB_CUR_STEP_UA);
  end
endmodule : ccrb_current_decode

//--- bench/ccrb_host_model.sv
`timescale 1ns/1ns
module ccrb_host_model (
  input wire logic sys_clk,
  output ccrb_pkg::ccrb_req_t req,
  input wire logic [7:0] rdata
);
  import ccrb_pkg::*;
  initial req = '0;
  // host leaves the 200mV system voltage headroom unchecked; charge voltage is never programmed
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge sys_clk);
    #5;
    req = '{wr_en: w, rd_en: !w, addr: a, wdata: d};
    @(posedge sys_clk);
    #5;
    q = rdata;
    // released lines show the inverse so a stale value never looks valid
    req = '{wr_en: 1'b0, rd_en: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : ccrb_host_model

//--- bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  import ccrb_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic cool = 1'b0;
  logic present = 1'b0;
  logic [7:0] rdata;
  ccrb_req_t req;
  ccrb_ctrl_t ctrl;
  int mismatches = 0;
  int cmp_count = 0;
  int c;
  int term_tbl[4] = '{10, 15, 20, 30};
  int hr_tbl[4] = '{0, 3, 5, 7};
  always #25 sys_clk = ~sys_clk;
  ccrb_charger_config dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .req(req),
    .battery_cool_or_warm(cool),
    .charger_input_present(present),
    .rdata(rdata),
    .ctrl(ctrl)
  );
  ccrb_host_model host (
    .sys_clk(sys_clk),
    .req(req),
    .rdata(rdata)
  );
  task automatic finish_test();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    // ctrl settles one edge after the write is taken, within the two-edge wait
    host.xfer(1'b1, a, d, q);
    repeat (2) @(posedge sys_clk);
    #5;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host.xfer(1'b0, a, 8'h00, q);
    check("rdata", 32'(q), 32'(exp));
  endtask : rd_chk
  task automatic wait_sync();
    repeat (4) @(posedge sys_clk);
    #5;
  endtask : wait_sync
  initial begin
    repeat (6) @(posedge sys_clk);
    #5;
    rst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #5;
    rd_chk(8'h22, 8'hF8);
    rd_chk(8'h23, 8'h10);
    rd_chk(8'h24, 8'h05);
    rd_chk(8'h25, 8'h04);
    rd_chk(8'h26, 8'h00);
    check("precharge_mv", 32'(ctrl.precharge_mv), 3000);
    check("charge_ua", 32'(ctrl.charge_ua), 15000);
    for (int i = 0; i < 8; i++) begin
      wr(8'h22, {i[2:0], i[1:0], i[2:0]});
      check("precharge_mv", 32'(ctrl.precharge_mv), 2300 + 100 * i);
      check("term_pct_x2", 32'(ctrl.term_pct_x2), term_tbl[i % 4]);
      check("topoff_min", 32'(ctrl.topoff_min), 5 * i);
      rd_chk(8'h22, {i[2:0], i[1:0], i[2:0]});
      c = 8'h18 + i;
      wr(8'h23, {i[2:0], c[4:0]});
      check("die_temp_c", 32'(ctrl.die_temp_c), (i > 3) ? 100 : 60 + 10 * i);
      check("system_mv", 32'(ctrl.system_mv), (c > 27) ? 4800 : 4100 + 25 * c);
      rd_chk(8'h23, {i[2:0], c[4:0]});
      c = 8'h23 + i;
      wr(8'h24, {c[5:0], i[1:0]});
      check("charge_ua", 32'(ctrl.charge_ua), ((c >= 39) ? 40 : c + 1) * 7500);
      check("safety_timer_h", 32'(ctrl.safety_timer_h), hr_tbl[i % 4]);
      rd_chk(8'h24, {c[5:0], i[1:0]});
    end
    wr(8'h24, 8'h40);
    wr(8'h25, 8'hFF);
    rd_chk(8'h25, 8'hFE);
    check("charge_ua", 32'(ctrl.charge_ua), 127500);
    check("thermistor_active", 32'(ctrl.thermistor_active), 0);
    cool = 1'b1;
    wait_sync();
    check("charge_ua", 32'(ctrl.charge_ua), 300000);
    present = 1'b1;
    wait_sync();
    check("thermistor_active", 32'(ctrl.thermistor_active), 1);
    wr(8'h25, 8'h00);
    check("thermistor_active", 32'(ctrl.thermistor_active), 0);
    check("charge_ua", 32'(ctrl.charge_ua), 7500);
    present = 1'b0;
    wr(8'h25, 8'h02);
    wait_sync();
    check("thermistor_active", 32'(ctrl.thermistor_active), 0);
    // reset in mid-run must bring the config registers back to their reset values, read back here for 0x22 and 0x25 only; the input synchronisers have no reset
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #5;
    rst = 1'b0;
    @(posedge sys_clk);
    #5;
    check("precharge_mv", 32'(ctrl.precharge_mv), 3000);
    check("term_pct_x2", 32'(ctrl.term_pct_x2), 30);
    check("thermistor_active", 32'(ctrl.thermistor_active), 0);
    rd_chk(8'h22, 8'hF8);
    rd_chk(8'h25, 8'h04);
    wr(8'h26, 8'hFF);
    rd_chk(8'h26, 8'h00);
    finish_test();
  end
endmodule : testbench
